// *** common/cgodr_pkg.sv ***
// constants for the clock generator output and divider register bytes
package cgodr_pkg;
	// ----------------------------------------
	// register indexes
	// ----------------------------------------
	localparam logic [7:0] CGODR_IDX_OUTPUT_CONTROL  = 8'h03;
	localparam logic [7:0] CGODR_IDX_CPU_DIV_HIGH    = 8'h04;
	localparam logic [7:0] CGODR_IDX_CPU_DIV_LOW     = 8'h05;
	localparam logic [7:0] CGODR_IDX_SPARE_SIX       = 8'h06;
	localparam logic [7:0] CGODR_IDX_SPARE_SEVEN     = 8'h07;
	localparam logic [7:0] CGODR_IDX_SPARE_EIGHT     = 8'h08;
	localparam logic [7:0] CGODR_IDX_PANEL_DIV_LOW   = 8'h09;
	localparam logic [7:0] CGODR_IDX_STATUS          = 8'h0a;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CGODR_BASE_EN_BIT       = 5;
	localparam int CGODR_EDGE_HI_BIT       = 4;
	localparam int CGODR_EDGE_LO_BIT       = 3;
	localparam int CGODR_DIV_BIT8_POS      = 0;
	localparam int CGODR_PANEL_BIT8_POS    = 7;
	localparam int CGODR_STRAP_B_POS       = 7;
	localparam int CGODR_STRAP_C_POS       = 6;
	localparam int CGODR_REQ0_POS          = 5;
	localparam int CGODR_REQ1_POS          = 4;
	localparam int CGODR_REQ2_POS          = 3;

	// ----------------------------------------
	// encodings and reset values
	// ----------------------------------------
	localparam logic [1:0] CGODR_EDGE_MEDIUM   = 2'h1;
	localparam logic [1:0] CGODR_EDGE_FAST     = 2'h2;
	localparam logic [1:0] CGODR_EDGE_RESERVED = 2'h3;
	localparam logic       CGODR_BASE_EN_RST   = 1'b1;
	localparam logic [1:0] CGODR_EDGE_RST      = CGODR_EDGE_FAST;
	localparam logic [2:0] CGODR_PERMIT_RST    = 3'h0;
	localparam logic       CGODR_DIV_BIT8_RST  = 1'b0;
	// strap pair {c,b} that selects the 166 setting
	localparam logic [1:0] CGODR_STRAP_166     = 2'h0;
	localparam logic [7:0] CGODR_DIV_LOW_166   = 8'h7d;
	localparam logic [7:0] CGODR_DIV_LOW_OTHER = 8'h00;
	localparam logic [7:0] CGODR_SPARE_SIX_VAL = 8'hcf;

	typedef enum logic [1:0]
	{
		CGODR_SETTLE_A = 2'b00,
		CGODR_SETTLE_B = 2'b01,
		CGODR_LATCH    = 2'b10,
		CGODR_RUN      = 2'b11
	} cgodr_start_e;

	function automatic logic [7:0] cgodr_div_low_default(input logic [1:0] strap_cb);
		return (strap_cb == CGODR_STRAP_166) ? CGODR_DIV_LOW_166 : CGODR_DIV_LOW_OTHER;
	endfunction : cgodr_div_low_default
endpackage : cgodr_pkg

// *** verilog/cgodr_sync.sv ***
// two flip-flop synchroniser for pin inputs
module cgodr_sync
	#(
	parameter int         WIDTH     = 1,
	parameter logic [7:0] RESET_VAL = 8'h00
	)
	(
	input  wire logic             i_clock,
	input  wire logic             i_rst_b,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
	);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb
	begin
		meta_d = i_rst_b ? i_async : RESET_VAL[WIDTH-1:0];
		sync_d = i_rst_b ? meta_q : RESET_VAL[WIDTH-1:0];
	end

	always_ff @(posedge i_clock)
	begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	assign o_sync = sync_q;
endmodule : cgodr_sync

// *** verilog/cgodr_regs.sv ***
// output control, divider and status register bytes of the clock generator
module cgodr_regs
	import cgodr_pkg::*;
	(
	input  wire logic       i_clock,
	input  wire logic       i_rst_b,
	input  wire logic [7:0] i_reg_index,
	input  wire logic       i_reg_write,
	input  wire logic [7:0] i_reg_wdata,
	output logic      [7:0] o_reg_rdata,
	input  wire logic       i_processor_clock_halt_n,
	input  wire logic       i_clock_request0_n,
	input  wire logic       i_clock_request1_n,
	input  wire logic       i_clock_request2_n,
	input  wire logic       i_freq_strap_b,
	input  wire logic       i_freq_strap_c,
	input  wire logic [8:0] i_panel_feedback_div,
	output logic            o_base_clock_enable,
	output logic      [1:0] o_base_edge_rate,
	output logic      [2:0] o_proc_output_enable,
	output logic      [8:0] o_proc_feedback_div,
	output logic            o_straps_latched
	);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic       halt_n_s;
	logic [2:0] request_s;
	logic [1:0] strap_s;

	cgodr_sync #(.WIDTH(1), .RESET_VAL(8'h01)) u_sync_halt
	(
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_async (i_processor_clock_halt_n),
		.o_sync  (halt_n_s)
	);

	cgodr_sync #(.WIDTH(3), .RESET_VAL(8'h07)) u_sync_request
	(
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_async ({i_clock_request2_n, i_clock_request1_n, i_clock_request0_n}),
		.o_sync  (request_s)
	);

	cgodr_sync #(.WIDTH(2), .RESET_VAL(8'h00)) u_sync_strap
	(
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_async ({i_freq_strap_c, i_freq_strap_b}),
		.o_sync  (strap_s)
	);

	// ----------------------------------------
	// state
	// ----------------------------------------
	cgodr_start_e start_q;
	cgodr_start_e start_d;
	logic         base_en_q;
	logic         base_en_d;
	logic [1:0]   edge_q;
	logic [1:0]   edge_d;
	logic [2:0]   permit_q;
	logic [2:0]   permit_d;
	logic         div_bit8_q;
	logic         div_bit8_d;
	logic [7:0]   div_low_q;
	logic [7:0]   div_low_d;
	logic [1:0]   strap_q;
	logic [1:0]   strap_d;
	logic [7:0]   rdata_q;
	logic [7:0]   rdata_d;
	logic [2:0]   out_en_q;
	logic [2:0]   out_en_d;
	logic         wr_ctrl;
	logic         wr_high;
	logic         wr_low;

	assign wr_ctrl = i_reg_write && (i_reg_index == CGODR_IDX_OUTPUT_CONTROL);
	assign wr_high = i_reg_write && (i_reg_index == CGODR_IDX_CPU_DIV_HIGH);
	assign wr_low  = i_reg_write && (i_reg_index == CGODR_IDX_CPU_DIV_LOW);

	// ----------------------------------------
	// strap capture after reset release
	// ----------------------------------------
	always_comb
	begin
		start_d = start_q;
		strap_d = strap_q;
		unique case (start_q)
			CGODR_SETTLE_A: start_d = CGODR_SETTLE_B;
			CGODR_SETTLE_B: start_d = CGODR_LATCH;
			CGODR_LATCH:
			begin
				strap_d = strap_s;
				start_d = CGODR_RUN;
			end
			CGODR_RUN: start_d = CGODR_RUN;
		endcase
		if (!i_rst_b)
		begin
			start_d = CGODR_SETTLE_A;
			strap_d = 2'h0;
		end
	end

	always_ff @(posedge i_clock)
	begin
		start_q <= start_d;
		strap_q <= strap_d;
	end

	// ----------------------------------------
	// writable fields
	// ----------------------------------------
	always_comb
	begin
		base_en_d  = base_en_q;
		edge_d     = edge_q;
		permit_d   = permit_q;
		div_bit8_d = div_bit8_q;
		div_low_d  = div_low_q;
		if (start_q == CGODR_LATCH)
		begin
			div_low_d = cgodr_div_low_default(strap_s);
		end
		if (wr_ctrl)
		begin
			base_en_d = i_reg_wdata[CGODR_BASE_EN_BIT];
			edge_d    = i_reg_wdata[CGODR_EDGE_HI_BIT:CGODR_EDGE_LO_BIT];
			permit_d  = {i_reg_wdata[0], i_reg_wdata[1], i_reg_wdata[2]};
		end
		if (wr_high)
		begin
			div_bit8_d = i_reg_wdata[CGODR_DIV_BIT8_POS];
		end
		if (wr_low)
		begin
			div_low_d = i_reg_wdata;
		end
		if (!i_rst_b)
		begin
			base_en_d  = CGODR_BASE_EN_RST;
			edge_d     = CGODR_EDGE_RST;
			permit_d   = CGODR_PERMIT_RST;
			div_bit8_d = CGODR_DIV_BIT8_RST;
			div_low_d  = CGODR_DIV_LOW_OTHER;
		end
	end

	always_ff @(posedge i_clock)
	begin
		base_en_q  <= base_en_d;
		edge_q     <= edge_d;
		permit_q   <= permit_d;
		div_bit8_q <= div_bit8_d;
		div_low_q  <= div_low_d;
	end

	// ----------------------------------------
	// processor pair gating
	// ----------------------------------------
	// a pair stops only when its permit is set and the halt pin is low
	always_comb
	begin
		out_en_d = ~(permit_q & {3{~halt_n_s}});
		if (!i_rst_b)
		begin
			out_en_d = 3'h7;
		end
	end

	always_ff @(posedge i_clock)
	begin
		out_en_q <= out_en_d;
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_comb
	begin
		rdata_d  = 8'h00;
		unique case (i_reg_index)
			CGODR_IDX_OUTPUT_CONTROL:
			begin
				rdata_d[CGODR_BASE_EN_BIT]                   = base_en_q;
				rdata_d[CGODR_EDGE_HI_BIT:CGODR_EDGE_LO_BIT] = edge_q;
				rdata_d[2:0] = {permit_q[0], permit_q[1], permit_q[2]};
			end
			CGODR_IDX_CPU_DIV_HIGH: rdata_d[CGODR_DIV_BIT8_POS] = div_bit8_q;
			CGODR_IDX_CPU_DIV_LOW:  rdata_d = div_low_q;
			CGODR_IDX_SPARE_SIX:    rdata_d = CGODR_SPARE_SIX_VAL;
			CGODR_IDX_SPARE_EIGHT:  rdata_d[CGODR_PANEL_BIT8_POS] = i_panel_feedback_div[8];
			CGODR_IDX_PANEL_DIV_LOW: rdata_d = i_panel_feedback_div[7:0];
			CGODR_IDX_STATUS:
			begin
				rdata_d[CGODR_STRAP_B_POS] = strap_q[0];
				rdata_d[CGODR_STRAP_C_POS] = strap_q[1];
				rdata_d[CGODR_REQ0_POS]    = request_s[0];
				rdata_d[CGODR_REQ1_POS]    = request_s[1];
				rdata_d[CGODR_REQ2_POS]    = request_s[2];
			end
			default: rdata_d = 8'h00;
		endcase
		if (!i_rst_b)
		begin
			rdata_d  = 8'h00;
		end
	end

	always_ff @(posedge i_clock)
	begin
		rdata_q <= rdata_d;
	end

	assign o_reg_rdata          = rdata_q;
	assign o_base_clock_enable  = base_en_q;
	assign o_base_edge_rate     = edge_q;
	assign o_proc_output_enable = out_en_q;
	assign o_proc_feedback_div  = {div_bit8_q, div_low_q};
	assign o_straps_latched     = (start_q == CGODR_RUN);
endmodule : cgodr_regs

// *** sim/cgodr_regs_assertions.sv ***
// concurrent checks on the register byte block ports
module cgodr_chk
	(
	input wire logic       i_clock,
	input wire logic       i_rst_b,
	input wire logic [7:0] i_reg_index,
	input wire logic       i_reg_write,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic       i_processor_clock_halt_n,
	input wire logic       i_clock_request0_n,
	input wire logic       i_clock_request1_n,
	input wire logic       i_clock_request2_n,
	input wire logic       i_freq_strap_b,
	input wire logic       i_freq_strap_c,
	input wire logic [8:0] i_panel_feedback_div,
	input wire logic       o_base_clock_enable,
	input wire logic [1:0] o_base_edge_rate,
	input wire logic [2:0] o_proc_output_enable,
	input wire logic [8:0] o_proc_feedback_div,
	input wire logic       o_straps_latched
	);
	timeunit 1ns;
	timeprecision 1ps;
	wire w3 = i_reg_write && i_reg_index == 8'h03;
	wire w4 = i_reg_write && i_reg_index == 8'h04;
	wire w5 = i_reg_write && i_reg_index == 8'h05;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	property p_en; w3 |=> o_base_clock_enable == $past(i_reg_wdata[5]); endproperty
	a_en: assert property (p_en) else $error("base enable");
	property p_edge; w3 |=> o_base_edge_rate == $past(i_reg_wdata[4:3]); endproperty
	a_edge: assert property (p_edge) else $error("edge rate");
	property p_run; i_processor_clock_halt_n [*4] |=> o_proc_output_enable == 3'h7; endproperty
	a_run: assert property (p_run) else $error("pair stopped");
	property p_free; $rose(i_rst_b) |-> (o_proc_output_enable == 3'h7) [*3]; endproperty
	a_free: assert property (p_free) else $error("pair not free");
	property p_hi; w4 |=> o_proc_feedback_div[8] == $past(i_reg_wdata[0]); endproperty
	a_hi: assert property (p_hi) else $error("divider bit 8");
	property p_lo; w5 |=> o_proc_feedback_div[7:0] == $past(i_reg_wdata); endproperty
	a_lo: assert property (p_lo) else $error("divider low");
	property p_dflt; $rose(o_straps_latched) && !$past(i_reg_write) |->
		o_proc_feedback_div[7:0] == ({i_freq_strap_c, i_freq_strap_b} == 2'h0 ? 8'h7d : 8'h00); endproperty
	a_dflt: assert property (p_dflt) else $error("divider default");
	property p_pan; i_reg_index == 8'h09 |=> o_reg_rdata == $past(i_panel_feedback_div[7:0]); endproperty
	a_pan: assert property (p_pan) else $error("panel read");
	property p_stat; o_straps_latched && i_reg_index == 8'h0a |=> o_reg_rdata == {i_freq_strap_b, i_freq_strap_c,
		$past(i_clock_request0_n, 3), $past(i_clock_request1_n, 3), $past(i_clock_request2_n, 3), 3'h0}; endproperty
	a_stat: assert property (p_stat) else $error("status read");
	c_w3: cover property (w3);
	c_stop: cover property (o_proc_output_enable != 3'h7);
	c_latch: cover property ($rose(o_straps_latched));
endmodule : cgodr_chk

// *** sim/cgodr_host.sv ***
// byte access model of the serial bus engine
module cgodr_host
	(
	input  wire logic       i_clock,
	input  wire logic [7:0] i_reg_rdata,
	output logic      [7:0] o_reg_index = 8'h00,
	output logic            o_reg_write = 1'b0,
	output logic      [7:0] o_reg_wdata = 8'h00
	);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		@(posedge i_clock);
		#1;
		o_reg_index = idx;
		o_reg_wdata = d;
		o_reg_write = 1'b1;
		@(posedge i_clock);
		#1;
		o_reg_write = 1'b0;
		// released data does not keep the last value
		o_reg_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] idx, output logic [7:0] d);
		@(posedge i_clock);
		#1;
		o_reg_index = idx;
		@(posedge i_clock);
		#1;
		d = i_reg_rdata;
	endtask : rd
endmodule : cgodr_host

// *** sim/cgodr_regs_tb_top.sv ***
// self-checking bench for the register byte block
module cgodr_regs_tb_top
	;
	timeunit 1ns;
	timeprecision 1ps;
	logic       i_clock = 1'b0, i_rst_b = 1'b0, i_reg_write, i_processor_clock_halt_n = 1'b1;
	logic       i_clock_request0_n = 1'b1, i_clock_request1_n = 1'b1, i_clock_request2_n = 1'b1;
	logic       i_freq_strap_b, i_freq_strap_c, o_base_clock_enable, o_straps_latched;
	logic [7:0] i_reg_index, i_reg_wdata, o_reg_rdata, d, r, e;
	logic [8:0] i_panel_feedback_div, o_proc_feedback_div;
	logic [1:0] o_base_edge_rate;
	logic [2:0] o_proc_output_enable;
	int         err_total = 0, checked = 0;
	always #4 i_clock = ~i_clock;
	cgodr_regs dut (.*);
	cgodr_host host (.i_clock(i_clock), .i_reg_rdata(o_reg_rdata), .o_reg_index(i_reg_index),
		.o_reg_write(i_reg_write), .o_reg_wdata(i_reg_wdata));
	function automatic logic [2:0] exp_en(input logic [7:0] c, input logic h);
		return h ? 3'h7 : ~{c[0], c[1], c[2]};
	endfunction : exp_en
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic settle;
		repeat (4) @(posedge i_clock);
		#1;
	endtask : settle
	// halt pin held low through reset so free-running pairs are really tested
	task automatic do_reset(input int n);
		i_rst_b = 1'b0;
		i_processor_clock_halt_n = 1'b0;
		repeat (n) @(posedge i_clock);
		#1;
		i_rst_b = 1'b1;
		settle();
		host.rd(8'h03, r);
		chk({r, o_base_clock_enable, o_base_edge_rate, o_proc_output_enable}, {8'h30, 1'b1, 2'h2, 3'h7});
		host.rd(8'h05, r);
		e = ({i_freq_strap_c, i_freq_strap_b} == 2'h0) ? 8'h7d : 8'h00;
		chk({o_straps_latched, o_proc_feedback_div, r}, {1'b1, 1'b0, e, e});
		$display("test reset values done");
	endtask : do_reset
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	initial
	begin
		#50000;
		err_total++;
		end_sim();
	end
	initial
	begin
		void'($urandom(32'hee46));
		{i_freq_strap_b, i_freq_strap_c} = 2'($urandom);
		i_panel_feedback_div = 9'($urandom);
		do_reset(20);
		for (int k = 0; k < 4; k++)
		begin
			d = 8'($urandom);
			d[4:3] = 2'(k);
			if (k == 3)
				d[2:0] = 3'h7;
			host.wr(8'h03, d);
			i_processor_clock_halt_n = 1'b0;
			settle();
			chk({o_base_clock_enable, o_base_edge_rate, o_proc_output_enable}, {d[5:3], exp_en(d, 1'b0)});
			i_processor_clock_halt_n = 1'b1;
			settle();
			host.rd(8'h03, r);
			chk({r, o_proc_output_enable}, {2'h0, d[5:0], exp_en(d, 1'b1)});
		end
		$display("test output control done");
		for (int k = 0; k < 3; k++)
		begin
			d = 8'($urandom);
			e = (k == 0) ? 8'hff : 8'($urandom);
			host.wr(8'h04, d);
			host.wr(8'h05, e);
			chk(o_proc_feedback_div, {d[0], e});
			host.rd(8'h04, r);
			chk(r, {7'h00, d[0]});
		end
		$display("test divider done");
		for (int k = 0; k < 2; k++)
		begin
			{i_clock_request0_n, i_clock_request1_n, i_clock_request2_n} = 3'($urandom);
			i_panel_feedback_div = 9'($urandom);
			host.wr(8'h09, ~i_panel_feedback_div[7:0]);
			settle();
			host.rd(8'h09, r);
			chk(r, i_panel_feedback_div[7:0]);
			host.rd(8'h08, r);
			chk(r, {i_panel_feedback_div[8], 7'h00});
			host.rd(8'h0a, r);
			chk(r, {i_freq_strap_b, i_freq_strap_c, i_clock_request0_n, i_clock_request1_n, i_clock_request2_n, 3'h0});
			host.rd(8'h20, r);
			chk(r, 8'h00);
		end
		host.rd(8'h07, r);
		chk(r, 8'h00);
		$display("test read only bytes done");
		host.wr(8'h03, 8'h0f);
		host.wr(8'h04, 8'hff);
		{i_freq_strap_b, i_freq_strap_c} = ({i_freq_strap_b, i_freq_strap_c} == 2'h0) ? 2'(1 + $urandom % 3) : 2'h0;
		do_reset(5);
		end_sim();
	end
endmodule : cgodr_regs_tb_top
bind cgodr_regs cgodr_chk u_chk (.*);
